// ===== logic/uhc_cfg_extras.sv
/*
 * Configuration-space extras: retry limit, bus release number, frame
 * length trim, port wake mask and power-management list header.
 * Assumes a dword configuration access port with byte enables, one
 * access taken per request cycle, answered the next cycle.
 */
// Operation
// R1: retry limit byte 41h, reset 00h
// R2: zero limit disables retry checking
// R3: timeout is value times clock period
// R4: retries beyond limit set unrecoverable error
// R5: release number at 60h reads 20h
// R6: microframe is 59488 plus trim clocks
// R7: one trim step is sixteen bit times
// R8: trim at 61h resets to 20h
// R9: new trim applies to SOF counter
// R10: host writes trim upper bits zero
// R11: wake mask 16-bit at 62h, reset 0007h
// R12: wake bits 15..1 map physical ports
// R13: wake mask has no operational effect
// R14: capability identifier reads 01h
// R15: fixed layout of power-management fields
// R16: only one power-management list entry
// R17: capability pointer reads DCh
// R18: retry count clears on clean completion
`include "uhc_cfg_map.svh"
`default_nettype none
module uhc_cfg_extras
    import uhc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire uhc_cfg_req_t cfg_req,
    output uhc_cfg_rsp_t cfg_rsp,
    input wire logic retry_pulse,
    input wire logic done_pulse,
    input wire logic error_clear,
    input wire logic sof_tick,
    input wire logic [15:0] pm_caps,
    input wire logic [15:0] pm_ctrl,
    input wire logic [7:0] pm_bridge,
    input wire logic [7:0] pm_data,
    output logic unrecoverable_error_flag,
    output logic sof_pulse,
    output logic [5:0] frame_length_trim,
    output logic [15:0] port_wake_mask,
    output logic [7:0] retry_count
);
    logic [7:0] retry_limit_ff;
    logic [7:0] frame_trim_ff;
    logic [15:0] wake_mask_ff;
    logic error_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [7:0] byte_rd [4];
    logic [3:0] wr_hit;
    logic error_event;

    // per-byte read mux and write decode
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            logic [7:0] baddr;
            assign baddr = {cfg_req.addr[7:2], 2'b00} + 8'(gi);
            assign wr_hit[gi] = cfg_req.req && cfg_req.wr && cfg_req.be[gi];
            always_comb begin
                if (baddr == `UHC_OFF_CAP_PTR) begin
                    byte_rd[gi] = `UHC_OFF_PM_BASE; // R17
                end else if (baddr == `UHC_OFF_RETRY_LIMIT) begin
                    byte_rd[gi] = retry_limit_ff; // R1
                end else if (baddr == `UHC_OFF_BUS_RELEASE) begin
                    byte_rd[gi] = `UHC_VAL_BUS_RELEASE; // R5
                end else if (baddr == `UHC_OFF_FRAME_TRIM) begin
                    byte_rd[gi] = frame_trim_ff;
                end else if (baddr == `UHC_OFF_WAKE_LO) begin
                    byte_rd[gi] = wake_mask_ff[7:0];
                end else if (baddr == `UHC_OFF_WAKE_HI) begin
                    byte_rd[gi] = wake_mask_ff[15:8];
                end else if (baddr == `UHC_OFF_PM_BASE + `UHC_PM_CAPABILITY_IDENTIFIER_OFS) begin
                    byte_rd[gi] = `UHC_VAL_CAPABILITY_IDENTIFIER; // R14
                end else if (baddr == `UHC_OFF_PM_BASE + `UHC_PM_NEXT_OFS) begin
                    byte_rd[gi] = `UHC_VAL_NEXT_PTR; // R16
                end else if (baddr == `UHC_OFF_PM_BASE + `UHC_PM_CAPS_OFS) begin
                    byte_rd[gi] = pm_caps[7:0]; // R15
                end else if (baddr == `UHC_OFF_PM_BASE + `UHC_PM_CAPS_OFS + 8'h01) begin
                    byte_rd[gi] = pm_caps[15:8];
                end else if (baddr == `UHC_OFF_PM_BASE + `UHC_PM_CTRL_OFS) begin
                    byte_rd[gi] = pm_ctrl[7:0];
                end else if (baddr == `UHC_OFF_PM_BASE + `UHC_PM_CTRL_OFS + 8'h01) begin
                    byte_rd[gi] = pm_ctrl[15:8];
                end else if (baddr == `UHC_OFF_PM_BASE + `UHC_PM_BRIDGE_OFS) begin
                    byte_rd[gi] = pm_bridge;
                end else if (baddr == `UHC_OFF_PM_BASE + `UHC_PM_DATA_OFS) begin
                    byte_rd[gi] = pm_data;
                end else begin
                    byte_rd[gi] = 8'h00;
                end
            end
        end
    endgenerate

    assign nxt_rdata = {byte_rd[3], byte_rd[2], byte_rd[1], byte_rd[0]};

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            retry_limit_ff <= `UHC_RST_RETRY_LIMIT; // R1
        end else if (cfg_req.addr[7:2] == 6'h10 && wr_hit[1]) begin
            retry_limit_ff <= cfg_req.wdata[15:8]; // R1
        end
    end

    // upper trim bits stored as written; host keeps them zero R10
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            frame_trim_ff <= `UHC_RST_FRAME_TRIM; // R8
        end else if (cfg_req.addr[7:2] == 6'h18 && wr_hit[1]) begin
            frame_trim_ff <= cfg_req.wdata[15:8]; // R9
        end
    end

    // information only: drives nothing inside R13
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wake_mask_ff <= `UHC_RST_WAKE_MASK; // R11
        end else if (cfg_req.addr[7:2] == 6'h18) begin
            if (wr_hit[2]) begin
                wake_mask_ff[7:0] <= cfg_req.wdata[23:16]; // R12
            end
            if (wr_hit[3]) begin
                wake_mask_ff[15:8] <= cfg_req.wdata[31:24];
            end
        end
    end

    // sticky error: a new event wins over a clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            error_ff <= 1'b0;
        end else if (error_event) begin
            error_ff <= 1'b1; // R4
        end else if (error_clear) begin
            error_ff <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ack_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= cfg_req.req;
            rdata_ff <= (cfg_req.req && !cfg_req.wr) ? nxt_rdata : 32'h0000_0000;
        end
    end

    uhc_retry_watch u_retry (
        .ref_clk(ref_clk),
        .rst(rst),
        .limit(retry_limit_ff),
        .retry_pulse(retry_pulse),
        .done_pulse(done_pulse),
        .error_pulse(error_event),
        .count(retry_count)
    );

    uhc_sof_timer u_sof (
        .ref_clk(ref_clk),
        .rst(rst),
        .tick(sof_tick),
        .trim(frame_trim_ff[`UHC_TRIM_MSB:`UHC_TRIM_LSB]),
        .sof_pulse(sof_pulse)
    );

    assign cfg_rsp.ack = ack_ff;
    assign cfg_rsp.rdata = rdata_ff;
    assign unrecoverable_error_flag = error_ff;
    assign frame_length_trim = frame_trim_ff[`UHC_TRIM_MSB:`UHC_TRIM_LSB];
    assign port_wake_mask = wake_mask_ff;
endmodule
`default_nettype wire

// ===== logic/uhc_cfg_map.svh
/*
 * Offsets, reset values, field positions and timing counts of the
 * configuration extras. Assumes byte offsets within the function's
 * configuration space.
 */
`ifndef UHC_CFG_MAP_SVH
`define UHC_CFG_MAP_SVH

`define UHC_OFF_CAP_PTR 8'h34
`define UHC_OFF_RETRY_LIMIT 8'h41
`define UHC_OFF_BUS_RELEASE 8'h60
`define UHC_OFF_FRAME_TRIM 8'h61
`define UHC_OFF_WAKE_LO 8'h62
`define UHC_OFF_WAKE_HI 8'h63
`define UHC_OFF_PM_BASE 8'hDC
`define UHC_PM_CAPABILITY_IDENTIFIER_OFS 8'h00
`define UHC_PM_NEXT_OFS 8'h01
`define UHC_PM_CAPS_OFS 8'h02
`define UHC_PM_CTRL_OFS 8'h04
`define UHC_PM_BRIDGE_OFS 8'h06
`define UHC_PM_DATA_OFS 8'h07

`define UHC_RST_RETRY_LIMIT 8'h00
`define UHC_VAL_BUS_RELEASE 8'h20
`define UHC_RST_FRAME_TRIM 8'h20
`define UHC_RST_WAKE_MASK 16'h0007
`define UHC_VAL_CAPABILITY_IDENTIFIER 8'h01
`define UHC_VAL_NEXT_PTR 8'h00

`define UHC_TRIM_MSB 5
`define UHC_TRIM_LSB 0
`define UHC_TRIM_STEP_BITS 16
`define UHC_SOF_BASE_CLOCKS 16'hE860

`endif

// ===== logic/uhc_pkg.sv
/*
 * Types shared by the configuration extras. Assumes nothing outside.
 */
`default_nettype none
package uhc_pkg;
    typedef struct packed {
        logic req;
        logic wr;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } uhc_cfg_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } uhc_cfg_rsp_t;

    typedef enum logic [1:0] {
        UHC_RT_IDLE,
        UHC_RT_RETRYING,
        UHC_RT_TRIPPED
    } uhc_retry_state_t;
endpackage
`default_nettype wire

// ===== logic/uhc_retry_watch.sv
/*
 * Counts consecutive target retries of one transaction against the
 * programmed limit. Assumes one retry and done pulse per PCI clock.
 */
`include "uhc_cfg_map.svh"
`default_nettype none
module uhc_retry_watch
    import uhc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] limit,
    input wire logic retry_pulse,
    input wire logic done_pulse,
    output logic error_pulse,
    output logic [7:0] count
);
    uhc_retry_state_t state_ff;
    uhc_retry_state_t nxt_state;
    logic [7:0] count_ff;
    logic [7:0] nxt_count;

    always_comb begin
        nxt_state = state_ff;
        nxt_count = count_ff;
        error_pulse = 1'b0;
        case (state_ff)
            UHC_RT_IDLE: begin
                if (retry_pulse && limit != 8'h00) begin // R2
                    nxt_count = 8'h01;
                    nxt_state = UHC_RT_RETRYING;
                end
            end
            UHC_RT_RETRYING: begin
                if (limit == 8'h00 || done_pulse) begin // R2 R18
                    nxt_count = 8'h00;
                    nxt_state = UHC_RT_IDLE;
                end else if (retry_pulse) begin
                    // each retry is one clock period of the limit R3
                    if (count_ff >= limit) begin // R4
                        error_pulse = 1'b1;
                        nxt_state = UHC_RT_TRIPPED;
                    end else begin
                        nxt_count = count_ff + 8'h01;
                    end
                end
            end
            UHC_RT_TRIPPED: begin
                if (done_pulse || limit == 8'h00) begin // R18
                    nxt_count = 8'h00;
                    nxt_state = UHC_RT_IDLE;
                end
            end
            default: begin
                nxt_state = UHC_RT_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_ff <= UHC_RT_IDLE;
            count_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            count_ff <= nxt_count;
        end
    end

    assign count = count_ff;
endmodule
`default_nettype wire

// ===== logic/uhc_sof_timer.sv
/*
 * Microframe timer on the high-speed counter clock tick. Assumes a
 * one-cycle tick per counter clock period.
 */
`include "uhc_cfg_map.svh"
`default_nettype none
module uhc_sof_timer
    import uhc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic [5:0] trim,
    output logic sof_pulse
);
    logic [15:0] count_ff;
    logic [15:0] period;
    logic sof_ff;

    // one trim step adds one counter clock, sixteen bit times R7
    assign period = `UHC_SOF_BASE_CLOCKS + {10'h000, trim}; // R6

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count_ff <= 16'h0000;
        end else if (tick) begin
            if (count_ff >= period - 16'h0001) begin // R9
                count_ff <= 16'h0000;
            end else begin
                count_ff <= count_ff + 16'h0001;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sof_ff <= 1'b0;
        end else begin
            sof_ff <= tick && (count_ff >= period - 16'h0001);
        end
    end

    assign sof_pulse = sof_ff;
endmodule
`default_nettype wire

// ===== test/uhc_cfg_extras_chk.sv
/*
 * Concurrent checks on the configuration extras.
 * Assumes it is bound to uhc_cfg_extras and sees only its ports.
 */
`default_nettype none
module uhc_cfg_extras_chk
    import uhc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire uhc_cfg_req_t cfg_req,
    input wire uhc_cfg_rsp_t cfg_rsp,
    input wire logic retry_pulse,
    input wire logic done_pulse,
    input wire logic sof_tick,
    input wire logic [15:0] pm_caps,
    input wire logic unrecoverable_error_flag,
    input wire logic sof_pulse,
    input wire logic [5:0] frame_length_trim,
    input wire logic [15:0] port_wake_mask,
    input wire logic [7:0] retry_count
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire logic rd_on = cfg_req.req && !cfg_req.wr;
    wire logic wr_60 = cfg_req.req && cfg_req.wr && cfg_req.addr[7:2] == 6'h18;
    chk_ack_after_req: assert property (cfg_req.req |=> cfg_rsp.ack)
        else $error("request not answered next cycle");
    chk_ack_only_req: assert property (!cfg_req.req |=> !cfg_rsp.ack)
        else $error("answer without request");
    chk_release_value: assert property (rd_on && cfg_req.addr[7:2] == 6'h18
        |=> cfg_rsp.rdata[7:0] == 8'h20) else $error("release number wrong");
    chk_cap_ident: assert property (rd_on && cfg_req.addr[7:2] == 6'h37
        |=> cfg_rsp.rdata[7:0] == 8'h01) else $error("capability id wrong");
    chk_pm_layout: assert property (rd_on && cfg_req.addr[7:2] == 6'h37
        |=> cfg_rsp.rdata[31:16] == $past(pm_caps)) else $error("capabilities misplaced");
    chk_cap_pointer: assert property (rd_on && cfg_req.addr[7:2] == 6'h0D
        |=> cfg_rsp.rdata[7:0] == 8'hDC) else $error("capability pointer wrong");
    chk_trim_apply: assert property (wr_60 && cfg_req.be[1]
        |=> frame_length_trim == $past(cfg_req.wdata[13:8])) else $error("trim not applied");
    chk_wake_store: assert property (wr_60 && cfg_req.be[3:2] == 2'b11
        |=> port_wake_mask == $past(cfg_req.wdata[31:16])) else $error("wake mask not stored");
    chk_error_cause: assert property ($rose(unrecoverable_error_flag)
        |-> $past(retry_pulse) || $past(retry_pulse, 2)) else $error("error flag without retry");
    chk_clean_clear: assert property (done_pulse && !retry_pulse |=> retry_count == 8'h00)
        else $error("retry count not cleared");
    chk_sof_from_tick: assert property (sof_pulse |-> $past(sof_tick))
        else $error("microframe pulse without tick");
endmodule
bind uhc_cfg_extras uhc_cfg_extras_chk chk_i (.ref_clk(ref_clk), .rst(rst),
    .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .retry_pulse(retry_pulse),
    .done_pulse(done_pulse), .sof_tick(sof_tick), .pm_caps(pm_caps),
    .unrecoverable_error_flag(unrecoverable_error_flag), .sof_pulse(sof_pulse),
    .frame_length_trim(frame_length_trim), .port_wake_mask(port_wake_mask),
    .retry_count(retry_count));
`default_nettype wire

// ===== test/uhc_host_model.sv
/*
 * Configuring host: issues one configuration cycle per call of xfer.
 * Assumes the answer comes one cycle after the request cycle.
 */
`default_nettype none
module uhc_host_model
    import uhc_pkg::*;
(
    input wire logic ref_clk,
    output uhc_cfg_req_t req,
    input wire uhc_cfg_rsp_t rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req = '0;
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [3:0] be,
            input logic [31:0] wd, output logic [31:0] rd, output logic ok);
        @(posedge ref_clk);
        if (a[7:2] == 6'h18) wd[15:14] = 2'b00;
        #1 req = '{1'b1, wr, a, be, wd};
        @(posedge ref_clk);
        #1 ok = rsp.ack;
        rd = rsp.rdata;
        // idle lines show no stale value
        req = '{1'b0, ~wr, ~a, 4'h0, ~wd};
    endtask
endmodule
`default_nettype wire

// ===== test/usb_host_pci_config_extras_tb_top.sv
/*
 * Self-checking bench for the configuration extras.
 * Assumes the host model, checker and design are compiled before it.
 */
`default_nettype none
module usb_host_pci_config_extras_tb_top
    import uhc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst, retry_pulse, done_pulse, error_clear, sof_tick, ue, sof_pulse;
    logic tick_hold;
    int cyc;
    logic [15:0] pm_caps, pm_ctrl, wake, wm;
    logic [7:0] pm_bridge, pm_data, rc, lim;
    logic [5:0] trim, ft;
    uhc_cfg_req_t cfg_req;
    uhc_cfg_rsp_t cfg_rsp;
    integer seed, bad_count, num_checks;
    uhc_host_model host (.ref_clk(ref_clk), .req(cfg_req), .rsp(cfg_rsp));
    uhc_cfg_extras uut (.ref_clk(ref_clk), .rst(rst), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
        .retry_pulse(retry_pulse), .done_pulse(done_pulse), .error_clear(error_clear),
        .sof_tick(sof_tick), .pm_caps(pm_caps), .pm_ctrl(pm_ctrl), .pm_bridge(pm_bridge),
        .pm_data(pm_data), .unrecoverable_error_flag(ue), .sof_pulse(sof_pulse),
        .frame_length_trim(ft), .port_wake_mask(wm), .retry_count(rc));
    initial begin
        ref_clk = 0;
        forever #4 ref_clk = ~ref_clk;
    end
    // random ticks, or a steady tick while a microframe is timed
    always @(posedge ref_clk) #1 sof_tick <= tick_hold | 1'($random(seed));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] exp60(input logic [15:0] w, input logic [5:0] t);
        return {w, 2'b00, t, 8'h20};
    endfunction
    function automatic int sof_cycles(input logic [5:0] t);
        return 59488 + int'(t);
    endfunction
    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        logic k;
        host.xfer(1'b0, a, 4'hF, 32'h0, d, k);
        check({31'h0, k}, 32'h1);
        check(d & m, e & m);
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] v);
        logic [31:0] d;
        logic k;
        host.xfer(1'b1, a, be, v, d, k);
    endtask
    task automatic pulse(input int n, input logic clr);
        repeat (n) begin
            @(posedge ref_clk);
            #1 retry_pulse = 1;
            error_clear = clr;
            @(posedge ref_clk);
            #1 retry_pulse = 0;
            error_clear = 0;
        end
        @(posedge ref_clk);
        #1;
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        #(8 * 80000);
        bad_count++;
        conclude();
    end
    initial begin
        seed = 73;
        bad_count = 0;
        num_checks = 0;
        {retry_pulse, done_pulse, error_clear, sof_tick, tick_hold} = 5'h00;
        {pm_caps, pm_ctrl} = $random(seed);
        {pm_bridge, pm_data} = 16'($random(seed));
        rst = 1;
        repeat (5) @(posedge ref_clk);
        #1 rst = 0;
        rdchk(8'h34, 32'hFF, 32'hDC);
        rdchk(8'h40, 32'hFF00, 32'h0);
        rdchk(8'h60, 32'hFFFFFFFF, exp60(16'h0007, 6'h20));
        rdchk(8'hDC, 32'hFFFFFFFF, {pm_caps, 16'h0001});
        rdchk(8'hE0, 32'hFFFFFFFF, {pm_data, pm_bridge, pm_ctrl});
        rdchk(8'h80, 32'hFFFFFFFF, 32'h0);
        for (int i = 0; i < 6; i++) begin
            wake = (i == 0) ? 16'hFFFE : $random(seed);
            trim = (i == 1) ? 6'h3F : $random(seed);
            wr(8'h60, 4'hF, {wake, 2'b00, trim, 8'h5A});
            rdchk(8'h60, 32'hFFFFFFFF, exp60(wake, trim));
            check({26'h0, ft}, {26'h0, trim});
            check({16'h0, wm}, {16'h0, wake});
        end
        for (int i = 0; i < 3; i++) begin
            lim = (i == 0) ? 8'h01 : 8'h02 + ($random(seed) & 8'h05);
            wr(8'h40, 4'h2, {16'h0, lim, 8'h0});
            rdchk(8'h40, 32'hFF00, {16'h0, lim, 8'h0});
            pulse(lim, 1'b0);
            check({24'h0, rc}, {24'h0, lim});
            check({31'h0, ue}, 32'h0);
            // last pass clears in the very cycle of the error: the set must win
            pulse(1, i == 2);
            check({31'h0, ue}, 32'h1);
            error_clear = 1;
            @(posedge ref_clk);
            #1 error_clear = 0;
            done_pulse = 1;
            @(posedge ref_clk);
            #1 done_pulse = 0;
            check({31'h0, ue}, 32'h0);
            check({24'h0, rc}, 32'h0);
        end
        wr(8'h40, 4'h2, 32'h0);
        pulse(12, 1'b0);
        check({31'h0, ue}, 32'h0);
        check({24'h0, rc}, 32'h0);
        wr(8'h40, 4'h2, 32'h0000_0700);
        pulse(8, 1'b0);
        check({31'h0, ue}, 32'h1);
        // mid-run reset, then time one microframe with a steady tick
        rst = 1;
        tick_hold = 1;
        repeat (2) @(posedge ref_clk);
        #1 rst = 0;
        check({26'h0, ft}, 32'h20);
        check({16'h0, wm}, 32'h0007);
        check({31'h0, ue}, 32'h0);
        check({24'h0, rc}, 32'h0);
        trim = $random(seed);
        wr(8'h60, 4'h2, {16'h0, 2'b00, trim, 8'h00});
        cyc = 2;
        while (!sof_pulse && cyc < 70000) begin
            @(posedge ref_clk);
            #1 cyc++;
        end
        check(cyc, sof_cycles(trim));
        rdchk(8'h40, 32'hFF00, 32'h0);
        conclude();
    end
endmodule
`default_nettype wire
